// >>> lfr_cfg.svh
// Constants of the link frame handshake logic: CRC settings and widths.
// Assumes it is included by bare name by the package and by each module except the checker and the peer model.
`ifndef LFR_CFG_SVH
`define LFR_CFG_SVH

// ==========================================================================
// Frame CRC
// ==========================================================================
// Generator polynomial, MSB-first
`define LFR_CRC_POLY 32'h04C11DB7
// Start value loaded at the start of every frame
`define LFR_CRC_SEED 32'hFFFFFFFF
// Remainder left when a frame and its own CRC have been folded in
`define LFR_CRC_RESIDUE 32'h00000000
// Dword width on the link
`define LFR_DWORD_W 32

`endif

// >>> lfr_crc.sv
// Frame CRC accumulator: folds one dword per enabled clock.
// Assumes clear and fold are never asked for in the same cycle.
`timescale 1ns/1ps
`include "lfr_cfg.svh"

module lfr_crc
  import lfr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic fold,
  input wire lfr_dword_t word,
  output lfr_dword_t crc
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    lfr_dword_t crc; // Running remainder
  } lfr_crc_s;

  lfr_crc_s state_q; // Registered state
  lfr_crc_s state_d; // Next state

  // One dword step, bit-serial unrolled by the loop, MSB first
  function automatic lfr_dword_t lfr_crc_step(lfr_dword_t c, lfr_dword_t w);
    lfr_dword_t r;
    r = c;
    for (int i = `LFR_DWORD_W - 1; i >= 0; i--)
    begin
      if (r[`LFR_DWORD_W-1] ^ w[i])
      begin
        r = {r[`LFR_DWORD_W-2:0], 1'b0} ^ `LFR_CRC_POLY;
      end
      else
      begin
        r = {r[`LFR_DWORD_W-2:0], 1'b0};
      end
    end
    return r;
  endfunction : lfr_crc_step

  // Next remainder: clear reseeds, fold advances
  always_comb
  begin
    state_d = state_q;
    if (clear)
    begin
      state_d.crc = `LFR_CRC_SEED;
    end
    else if (fold)
    begin
      state_d.crc = lfr_crc_step(state_q.crc, word);
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '{crc: `LFR_CRC_SEED};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign crc = state_q.crc;

endmodule : lfr_crc

// >>> lfr_link_fsm.sv
// Link frame handshake: tail of the transmit machine, receive machine.
// Assumes one classified dword per clock from the physical layer and a
// transport layer that answers with levels in the same clock domain.
`timescale 1ns/1ps
`include "lfr_cfg.svh"

module lfr_link_fsm
  import lfr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic phyLinkUp,
  input wire lfr_prim_e rxPrim,
  input wire lfr_dword_t rxWord,
  output lfr_prim_e txPrim,
  output logic txIsData,
  output lfr_dword_t txWord,
  input wire logic trTxRequest,
  input wire logic trTxAvail,
  input wire logic trTxDone,
  input wire lfr_dword_t trTxData,
  output logic trTxTake,
  input wire logic trEscape,
  input wire logic trRxSpace,
  input wire logic trRxTerminate,
  input wire logic trRxGood,
  input wire logic trRxUnrecognized,
  input wire logic trRxError,
  output lfr_dword_t rxDataOut,
  output logic rxDataValid,
  output logic rxCrcValid,
  output logic txStatusGood,
  output logic txStatusBad,
  output logic txDmatSeen,
  output logic evIllegal,
  output logic evNoComm,
  output logic evRxAbort,
  output lfr_state_e linkState
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    lfr_state_e st;      // Link state
    lfr_dword_t rxData;  // Last dword passed upward
    logic rxValid;       // Pulse with rxData
    logic crcValid;      // Pulse on good CRC
    logic statGood;      // Pulse: peer reported R_OK
    logic statBad;       // Pulse: peer reported R_ERR
    logic dmat;          // Pulse: peer asked to end our frame
    logic illegal;       // Pulse: illegal transition
    logic noComm;        // Pulse: link dropped mid transfer
    logic rxAbort;       // Pulse: receive ended by unexpected dword
  } lfr_fsm_s;

  lfr_fsm_s state_q; // Registered state
  lfr_fsm_s state_d; // Next state
  lfr_prim_e txSel;  // Dword chosen for the next link slot
  logic txSend;      // A payload dword is taken this cycle
  logic txCrcClr;    // Reseed transmit CRC
  logic rxCrcClr;    // Reseed receive CRC
  logic rxFold;      // Received data dword enters the CRC
  lfr_dword_t txCrc; // Running transmit CRC
  lfr_dword_t rxCrc; // Running receive remainder

  // True for states that belong to a frame in flight
  function automatic logic lfr_in_frame(lfr_state_e s);
    return (s != ST_IDLE) && (s != ST_NO_COMM_ERROR) &&
      (s != ST_FRAME_ESCAPE);
  endfunction : lfr_in_frame

  // True for the four receive states where escape is honoured
  function automatic logic lfr_rx_body(lfr_state_e s);
    return (s == ST_RX_PAYLOAD) || (s == ST_RX_LOCAL_HOLD) ||
      (s == ST_RX_PEER_HOLD) || (s == ST_RX_CRC_OK);
  endfunction : lfr_rx_body

  // ========================================================================
  // Transmit selection and CRC control
  // ========================================================================
  // Payload only moves when nothing on the line stops it
  always_comb
  begin
    txSend = 1'b0;
    txSel = PR_SYNC;
    if (state_q.st == ST_TX_PAYLOAD || state_q.st == ST_TX_LOCAL_HOLD ||
        state_q.st == ST_TX_PEER_HOLD)
    begin
      txSend = phyLinkUp && !trEscape && trTxAvail && !trTxDone &&
        (rxPrim != PR_HOLD) && (rxPrim != PR_SYNC) &&
        (rxPrim != PR_DMAT);
    end
    case (state_q.st)
      ST_TX_PAYLOAD:
      begin
        // Local stall shows as HOLD, a peer stall as HOLDA
        txSel = txSend ? PR_DATA :
          (rxPrim == PR_HOLD ? PR_HOLDA : PR_HOLD);
      end
      ST_TX_LOCAL_HOLD:
      begin
        txSel = txSend ? PR_DATA : PR_HOLD;
      end
      ST_TX_PEER_HOLD:
      begin
        txSel = txSend ? PR_DATA : PR_HOLDA;
      end
      ST_TX_CRC: txSel = PR_CRC;
      ST_TX_END_OF_FRAME: txSel = PR_EOF;
      ST_TX_WAIT_STATUS: txSel = PR_WTRM;
      ST_RX_READY_CHECK: txSel = PR_R_RDY;
      ST_RX_WAIT_ROOM: txSel = PR_SYNC;
      ST_RX_PAYLOAD, ST_RX_CRC_CHECK, ST_RX_CRC_OK:
      begin
        // Terminate request only replaces R_IP while data flows
        txSel = (state_q.st == ST_RX_PAYLOAD && trRxTerminate) ?
          PR_DMAT : PR_R_IP;
      end
      ST_RX_LOCAL_HOLD: txSel = PR_HOLD;
      ST_RX_PEER_HOLD:
      begin
        txSel = trRxTerminate ? PR_DMAT : PR_HOLDA;
      end
      ST_RX_SUCCESS: txSel = PR_R_OK;
      ST_RX_FAILURE: txSel = PR_R_ERR;
      default: txSel = PR_SYNC;
    endcase
    txCrcClr = (state_q.st == ST_IDLE);
    rxCrcClr = (state_q.st == ST_RX_READY_CHECK);
    // Data arriving in a hold still rides on FIFO headroom
    rxFold = phyLinkUp && (rxPrim == PR_DATA) &&
      ((state_q.st == ST_RX_PAYLOAD) || (state_q.st == ST_RX_LOCAL_HOLD) ||
      (state_q.st == ST_RX_PEER_HOLD));
  end

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb
  begin
    state_d = state_q;
    state_d.rxValid = rxFold;
    state_d.crcValid = 1'b0;
    state_d.statGood = 1'b0;
    state_d.statBad = 1'b0;
    state_d.dmat = 1'b0;
    state_d.illegal = 1'b0;
    state_d.noComm = 1'b0;
    state_d.rxAbort = 1'b0;
    if (rxFold)
    begin
      state_d.rxData = rxWord;
    end
    if (!phyLinkUp && lfr_in_frame(state_q.st))
    begin
      // Link lost anywhere in a transfer fails it
      state_d.st = ST_NO_COMM_ERROR;
      state_d.noComm = 1'b1;
    end
    else if (trEscape && ((state_q.st == ST_TX_PAYLOAD) ||
      (state_q.st == ST_TX_LOCAL_HOLD) || (state_q.st == ST_TX_PEER_HOLD) ||
      lfr_rx_body(state_q.st)))
    begin
      // Escape outranks every dword on the line
      state_d.st = ST_FRAME_ESCAPE;
    end
    else
    begin
      case (state_q.st)
        ST_IDLE:
        begin
          // A peer request wins; our own frame waits for idle again
          if (rxPrim == PR_X_RDY)
          begin
            state_d.st = trRxSpace ? ST_RX_READY_CHECK : ST_RX_WAIT_ROOM;
          end
          else if (trTxRequest && phyLinkUp)
          begin
            state_d.st = ST_TX_PAYLOAD;
          end
        end
        ST_TX_PAYLOAD, ST_TX_LOCAL_HOLD:
        begin
          if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.illegal = 1'b1;
          end
          else if (rxPrim == PR_DMAT)
          begin
            state_d.st = ST_TX_CRC;
            state_d.dmat = 1'b1;
          end
          else if (trTxDone)
          begin
            state_d.st = ST_TX_CRC;
          end
          else if (rxPrim == PR_HOLD && trTxAvail)
          begin
            state_d.st = ST_TX_PEER_HOLD;
          end
          else if (!trTxAvail)
          begin
            // Payload state with HOLD and no data also parks here
            state_d.st = ST_TX_LOCAL_HOLD;
          end
          else if (rxPrim != PR_HOLD)
          begin
            state_d.st = ST_TX_PAYLOAD;
          end
        end
        ST_TX_PEER_HOLD:
        begin
          if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.illegal = 1'b1;
          end
          else if (rxPrim == PR_DMAT)
          begin
            state_d.st = ST_TX_CRC;
            state_d.dmat = 1'b1;
          end
          else if (rxPrim != PR_HOLD && trTxAvail)
          begin
            state_d.st = ST_TX_PAYLOAD;
          end
        end
        ST_TX_CRC, ST_TX_END_OF_FRAME:
        begin
          if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.illegal = 1'b1;
          end
          else
          begin
            // Each of these takes exactly one link slot
            state_d.st = (state_q.st == ST_TX_CRC) ?
              ST_TX_END_OF_FRAME : ST_TX_WAIT_STATUS;
          end
        end
        ST_TX_WAIT_STATUS:
        begin
          if (rxPrim == PR_R_OK)
          begin
            state_d.st = ST_IDLE;
            state_d.statGood = 1'b1;
          end
          else if (rxPrim == PR_R_ERR)
          begin
            state_d.st = ST_IDLE;
            state_d.statBad = 1'b1;
          end
          else if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.illegal = 1'b1;
          end
        end
        ST_RX_WAIT_ROOM:
        begin
          if (rxPrim == PR_X_RDY)
          begin
            // Without room keep answering SYNC
            if (trRxSpace)
            begin
              state_d.st = ST_RX_READY_CHECK;
            end
          end
          else
          begin
            state_d.st = ST_IDLE;
            state_d.rxAbort = 1'b1;
          end
        end
        ST_RX_READY_CHECK:
        begin
          if (rxPrim == PR_SOF)
          begin
            state_d.st = ST_RX_PAYLOAD;
          end
          else if (rxPrim != PR_X_RDY)
          begin
            state_d.st = ST_IDLE;
            state_d.rxAbort = 1'b1;
          end
        end
        ST_RX_PAYLOAD:
        begin
          case (rxPrim)
            PR_DATA:
            begin
              if (!trRxSpace)
              begin
                state_d.st = ST_RX_LOCAL_HOLD;
              end
            end
            PR_HOLD: state_d.st = ST_RX_PEER_HOLD;
            PR_EOF: state_d.st = ST_RX_CRC_CHECK;
            PR_WTRM: state_d.st = ST_RX_FAILURE;
            PR_SYNC:
            begin
              state_d.st = ST_IDLE;
              state_d.rxAbort = 1'b1;
            end
            default: state_d.st = ST_RX_PAYLOAD;
          endcase
        end
        ST_RX_LOCAL_HOLD:
        begin
          if (rxPrim == PR_EOF)
          begin
            // Headroom absorbs an EOF that was already in flight
            state_d.st = ST_RX_CRC_CHECK;
          end
          else if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.illegal = 1'b1;
          end
          else if (trRxSpace)
          begin
            state_d.st = (rxPrim == PR_HOLD) ?
              ST_RX_PEER_HOLD : ST_RX_PAYLOAD;
          end
        end
        ST_RX_PEER_HOLD:
        begin
          if (rxPrim == PR_EOF)
          begin
            state_d.st = ST_RX_CRC_CHECK;
          end
          else if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
            state_d.rxAbort = 1'b1;
          end
          else if (rxPrim != PR_HOLD)
          begin
            state_d.st = ST_RX_PAYLOAD;
          end
        end
        ST_RX_CRC_CHECK:
        begin
          // Remainder is settled on the first cycle here
          if (rxCrc == `LFR_CRC_RESIDUE)
          begin
            state_d.st = ST_RX_CRC_OK;
            state_d.crcValid = 1'b1;
          end
          else
          begin
            state_d.st = ST_RX_FAILURE;
          end
        end
        ST_RX_CRC_OK:
        begin
          if (trRxUnrecognized || trRxError)
          begin
            state_d.st = ST_RX_FAILURE;
          end
          else if (trRxGood)
          begin
            state_d.st = ST_RX_SUCCESS;
          end
        end
        ST_RX_SUCCESS, ST_RX_FAILURE, ST_FRAME_ESCAPE:
        begin
          if (rxPrim == PR_SYNC)
          begin
            state_d.st = ST_IDLE;
          end
        end
        ST_NO_COMM_ERROR:
        begin
          // Sit out the outage, then start clean
          if (phyLinkUp)
          begin
            state_d.st = ST_IDLE;
          end
        end
        default: state_d.st = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '{st: ST_IDLE, rxData: '0, default: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ========================================================================
  // Submodules
  // ========================================================================
  // Transmit CRC covers each payload dword as it is taken
  lfr_crc u_tx_crc (
    .clk(clk),
    .resetn(resetn),
    .clear(txCrcClr),
    .fold(txSend),
    .word(trTxData),
    .crc(txCrc)
  );

  // Receive CRC covers payload and the trailing CRC dword
  lfr_crc u_rx_crc (
    .clk(clk),
    .resetn(resetn),
    .clear(rxCrcClr),
    .fold(rxFold),
    .word(rxWord),
    .crc(rxCrc)
  );

  // Registered link output
  lfr_tx_out u_tx_out (
    .clk(clk),
    .resetn(resetn),
    .sel(txSel),
    .payload(trTxData),
    .crc(txCrc),
    .txPrim(txPrim),
    .txIsData(txIsData),
    .txWord(txWord)
  );

  assign trTxTake = txSend;
  assign rxDataOut = state_q.rxData;
  assign rxDataValid = state_q.rxValid;
  assign rxCrcValid = state_q.crcValid;
  assign txStatusGood = state_q.statGood;
  assign txStatusBad = state_q.statBad;
  assign txDmatSeen = state_q.dmat;
  assign evIllegal = state_q.illegal;
  assign evNoComm = state_q.noComm;
  assign evRxAbort = state_q.rxAbort;
  assign linkState = state_q.st;

endmodule : lfr_link_fsm

// >>> lfr_link_fsm_props.sv
// Checker of the link frame handshake, bound to its top module.
// Assumes outputs are registered and decided on each rising edge.
`timescale 1ns/1ps
module lfr_link_fsm_props
  import lfr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic phyLinkUp,
  input wire lfr_prim_e rxPrim,
  input wire lfr_dword_t rxWord,
  input wire lfr_prim_e txPrim,
  input wire logic trEscape,
  input wire logic trRxSpace,
  input wire lfr_dword_t rxDataOut,
  input wire logic rxDataValid,
  input wire logic rxCrcValid,
  input wire logic txStatusGood,
  input wire logic evIllegal,
  input wire logic evNoComm,
  input wire lfr_state_e linkState
);
  // Link up and no escape: the plain transition rows apply
  wire logic live = phyLinkUp && !trEscape;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ========
  // Transmit tail
  property p_nocomm;
    !phyLinkUp && linkState inside {ST_TX_PAYLOAD, ST_TX_PEER_HOLD}
      |=> linkState == ST_NO_COMM_ERROR && evNoComm;
  endproperty
  a_nocomm: assert property (p_nocomm)
    else $error("link loss not handled");
  property p_sync;
    live && rxPrim == PR_SYNC && linkState inside {ST_TX_PAYLOAD,
      ST_TX_LOCAL_HOLD, ST_TX_PEER_HOLD, ST_TX_CRC, ST_TX_END_OF_FRAME}
      |=> linkState == ST_IDLE && evIllegal;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync in frame not flagged");
  property p_eof;
    live && linkState == ST_TX_CRC && rxPrim != PR_SYNC
      |=> linkState == ST_TX_END_OF_FRAME ##1 txPrim == PR_EOF;
  endproperty
  a_eof: assert property (p_eof)
    else $error("crc not followed by eof");
  property p_good;
    live && linkState == ST_TX_WAIT_STATUS && rxPrim == PR_R_OK
      |=> txStatusGood && linkState == ST_IDLE;
  endproperty
  a_good: assert property (p_good)
    else $error("good status lost");
  // ========
  // Receive front
  property p_room;
    linkState == ST_RX_WAIT_ROOM |=> txPrim == PR_SYNC;
  endproperty
  a_room: assert property (p_room)
    else $error("wait room not idling");
  property p_rdata;
    live && linkState == ST_RX_PAYLOAD && rxPrim == PR_DATA && trRxSpace
      |=> rxDataValid && rxDataOut == $past(rxWord);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("received dword not passed up");
  property p_hold;
    live && linkState == ST_RX_PAYLOAD && rxPrim == PR_DATA && !trRxSpace
      |=> linkState == ST_RX_LOCAL_HOLD ##1 txPrim == PR_HOLD;
  endproperty
  a_hold: assert property (p_hold)
    else $error("no hold on full buffer");
  property p_crcok;
    linkState == ST_RX_CRC_OK && $past(linkState) != ST_RX_CRC_OK
      |-> rxCrcValid;
  endproperty
  a_crcok: assert property (p_crcok)
    else $error("crc valid not flagged");
endmodule : lfr_link_fsm_props
bind lfr_link_fsm lfr_link_fsm_props lfr_link_fsm_props_inst (.*);

// >>> lfr_peer_model.sv
// Peer link layer model feeding the receive dword stream.
// Assumes bench commands change just after a falling edge.
`timescale 1ns/1ps
module lfr_peer_model
  import lfr_pkg::*;
(
  input wire logic clk,
  input wire lfr_prim_e sendPrim,
  input wire lfr_dword_t sendWord,
  input wire logic answerGood,
  input wire logic [3:0] answerDelay,
  input wire lfr_prim_e txPrim,
  output lfr_prim_e rxPrim,
  output lfr_dword_t rxWord
);
  logic [3:0] waitCnt_q; // Cycles of WTRM seen so far
  // Counting lets the status answer come late as well as at once
  always_ff @(posedge clk)
    waitCnt_q <= (txPrim == PR_WTRM) ? waitCnt_q + 4'h1 : 4'h0;
  // Status once the delay ran out, otherwise the bench stream
  assign rxPrim = (txPrim == PR_WTRM && waitCnt_q >= answerDelay) ?
    (answerGood ? PR_R_OK : PR_R_ERR) : sendPrim;
  // Non-data dwords carry the inverse, never a stale payload
  assign rxWord = (rxPrim == PR_DATA) ? sendWord : ~sendWord;
endmodule : lfr_peer_model

// >>> lfr_pkg.sv
// Types shared by the link frame handshake logic.
// Assumes the physical layer hands over one classified dword per clock.
`include "lfr_cfg.svh"

package lfr_pkg;

  // ========================================================================
  // Link primitives, as classified on receive and selected on transmit
  // ========================================================================
  typedef enum logic [3:0] {
    PR_DATA,   // Payload dword, not a primitive
    PR_CRC,    // Transmit only: the accumulated frame CRC
    PR_SYNC,
    PR_X_RDY,
    PR_R_RDY,
    PR_SOF,
    PR_EOF,
    PR_HOLD,
    PR_HOLDA,
    PR_R_IP,
    PR_DMAT,
    PR_WTRM,
    PR_R_OK,
    PR_R_ERR,
    PR_OTHER   // Any other primitive
  } lfr_prim_e;

  // ========================================================================
  // Link states
  // ========================================================================
  typedef enum logic [4:0] {
    ST_IDLE,
    ST_TX_PAYLOAD,
    ST_TX_LOCAL_HOLD,
    ST_TX_PEER_HOLD,
    ST_TX_CRC,
    ST_TX_END_OF_FRAME,
    ST_TX_WAIT_STATUS,
    ST_RX_WAIT_ROOM,
    ST_RX_READY_CHECK,
    ST_RX_PAYLOAD,
    ST_RX_LOCAL_HOLD,
    ST_RX_PEER_HOLD,
    ST_RX_CRC_CHECK,
    ST_RX_CRC_OK,
    ST_RX_SUCCESS,
    ST_RX_FAILURE,
    ST_NO_COMM_ERROR,
    ST_FRAME_ESCAPE
  } lfr_state_e;

  typedef logic [`LFR_DWORD_W-1:0] lfr_dword_t;

endpackage : lfr_pkg

// >>> lfr_tx_out.sv
// Transmit output stage: registers the dword chosen by the state machine.
// Assumes the physical layer takes one dword per clock with no stall.
`timescale 1ns/1ps
`include "lfr_cfg.svh"

module lfr_tx_out
  import lfr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire lfr_prim_e sel,
  input wire lfr_dword_t payload,
  input wire lfr_dword_t crc,
  output lfr_prim_e txPrim,
  output logic txIsData,
  output lfr_dword_t txWord
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    lfr_prim_e prim;  // Primitive being sent
    logic isData;     // High when txWord carries payload or CRC
    lfr_dword_t word; // Payload or CRC dword
  } lfr_tx_out_s;

  lfr_tx_out_s state_q; // Registered state
  lfr_tx_out_s state_d; // Next state

  // Choose what goes on the link next; CRC travels as a data dword
  always_comb
  begin
    state_d.prim = sel;
    state_d.isData = (sel == PR_DATA) || (sel == PR_CRC);
    if (sel == PR_CRC)
    begin
      state_d.word = crc;
    end
    else if (sel == PR_DATA)
    begin
      state_d.word = payload;
    end
    else
    begin
      state_d.word = '0;
    end
  end

  // Idle link sends SYNC out of reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '{prim: PR_SYNC, isData: 1'b0, word: '0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign txPrim = state_q.prim;
  assign txIsData = state_q.isData;
  assign txWord = state_q.word;

endmodule : lfr_tx_out

// >>> link_frame_tx_tail_rx_fsm_tb_top.sv
// Bench of the link frame handshake: tx frames, rx frames, faults.
// Assumes outputs are settled by the falling edge after a decision.
`timescale 1ns/1ps
`include "lfr_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module link_frame_tx_tail_rx_fsm_tb_top
  import lfr_pkg::*;
;
  logic clk = 1'h0, resetn = 1'h0, phyLinkUp = 1'h1, trTxRequest = 1'h0;
  logic trTxAvail = 1'h0, trTxDone = 1'h0, trEscape = 1'h0;
  logic trRxSpace = 1'h1, trRxTerminate = 1'h0, trRxGood = 1'h0;
  logic trRxUnrecognized = 1'h0, trRxError = 1'h0, answerGood = 1'h1;
  logic trTxTake, txIsData, rxDataValid, rxCrcValid, txStatusGood;
  logic txStatusBad, txDmatSeen, evIllegal, evNoComm, evRxAbort;
  logic [3:0] answerDelay = 4'h0;
  lfr_prim_e sendPrim = PR_SYNC, rxPrim, txPrim;
  lfr_dword_t sendWord = '0, trTxData = '0, rxWord, txWord, rxDataOut;
  lfr_dword_t txCrc, rxCrc;
  lfr_state_e linkState;
  integer seed = 32'hA10E;
  int err_total = 0, samples_checked = 0, i, k;
  lfr_link_fsm lfr_link_fsm_inst (.*);
  lfr_peer_model lfr_peer_model_inst (.*);
  initial forever #50 clk = ~clk;
  // Watchdog cuts a hang short
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Expected CRC, folded MSB first
  function automatic lfr_dword_t fold(lfr_dword_t c, lfr_dword_t d);
    for (int b = 31; b >= 0; b--)
      c = {c[30:0], 1'h0} ^ ((c[31] ^ d[b]) ? `LFR_CRC_POLY : 32'h0);
    return c;
  endfunction : fold
  // One cycle of peer traffic; fresh random words, sendWord kept when held
  task automatic go(input lfr_prim_e p, input bit hold = 1'h0);
    sendPrim = p;
    trTxData = $random(seed);
    if (!hold)
      sendWord = $random(seed);
    #1;
    if (trTxTake === 1'h1)
      txCrc = fold(txCrc, trTxData);
    @(negedge clk);
  endtask : go
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1'h1;
    // ========
    // Transmit: done with prompt good status, DMAT with slow bad status
    for (k = 0; k < 2; k++)
    begin
      answerGood = (k == 0);
      answerDelay = 4'(3 * k);
      txCrc = `LFR_CRC_SEED;
      trTxRequest = 1'h1;
      trTxAvail = 1'h1;
      go(PR_R_IP);
      trTxRequest = 1'h0;
      for (i = 0; i < 4; i++)
      begin
        go(PR_R_IP);
        `CHK(txWord, trTxData);
      end
      trTxAvail = 1'h0;
      go(PR_R_IP);
      `CHK(txPrim, PR_HOLD);
      go(PR_HOLDA);
      `CHK(linkState, ST_TX_LOCAL_HOLD);
      trTxAvail = 1'h1;
      go(PR_HOLD);
      `CHK(linkState, ST_TX_PEER_HOLD);
      go(PR_HOLD);
      `CHK(txPrim, PR_HOLDA);
      go(PR_R_IP);
      trTxAvail = 1'h0;
      go(PR_R_IP);
      trTxAvail = 1'h1;
      go(PR_R_IP);
      `CHK(linkState, ST_TX_PAYLOAD);
      trTxAvail = 1'h0;
      go(PR_R_IP);
      trTxDone = (k == 0);
      go(k ? PR_DMAT : PR_R_IP);
      trTxDone = 1'h0;
      `CHK(txDmatSeen, k);
      go(PR_R_IP);
      `CHK(txWord, txCrc);
      `CHK({txIsData, txPrim}, {1'h1, PR_CRC});
      go(PR_R_IP);
      `CHK(txPrim, PR_EOF);
      go(PR_R_IP);
      `CHK(txPrim, PR_WTRM);
      for (i = 0; i < 9 && !(txStatusGood | txStatusBad); i++)
        go(PR_R_IP);
      `CHK({txStatusGood, txStatusBad}, {k == 0, k == 1});
      `CHK(linkState, ST_IDLE);
      // Peer keeps its status up until it sees SYNC again
      go(PR_SYNC);
    end
    // ========
    // Receive: good result, then unrecognized frame with DMAT
    for (k = 0; k < 2; k++)
    begin
      trRxSpace = 1'h0;
      go(PR_X_RDY);
      trRxSpace = 1'h1;
      go(PR_X_RDY);
      go(PR_X_RDY);
      `CHK(txPrim, PR_R_RDY);
      go(PR_SOF);
      rxCrc = `LFR_CRC_SEED;
      trRxTerminate = (k == 1);
      for (i = 0; i < 4; i++)
      begin
        go(PR_DATA);
        rxCrc = fold(rxCrc, sendWord);
        `CHK(rxDataOut, sendWord);
        `CHK(txPrim, k ? PR_DMAT : PR_R_IP);
      end
      trRxTerminate = 1'h0;
      sendWord = rxCrc;
      go(PR_DATA, 1'h1);
      go(PR_EOF);
      go(PR_R_IP);
      `CHK(rxCrcValid, 1'h1);
      go(PR_R_IP);
      `CHK(linkState, ST_RX_CRC_OK);
      trRxGood = (k == 0);
      trRxUnrecognized = (k == 1);
      go(PR_R_IP);
      `CHK(linkState, k ? ST_RX_FAILURE : ST_RX_SUCCESS);
      trRxGood = 1'h0;
      trRxUnrecognized = 1'h0;
      go(PR_SYNC);
    end
    // ========
    // Receive holds, abort by SYNC, then a stray dword in ready check
    go(PR_X_RDY);
    go(PR_SOF);
    trRxSpace = 1'h0;
    go(PR_DATA);
    trRxSpace = 1'h1;
    go(PR_R_IP);
    `CHK(linkState, ST_RX_PAYLOAD);
    go(PR_HOLD);
    go(PR_HOLD);
    `CHK(txPrim, PR_HOLDA);
    go(PR_R_IP);
    `CHK(linkState, ST_RX_PAYLOAD);
    go(PR_SYNC);
    `CHK(evRxAbort, 1'h1);
    go(PR_X_RDY);
    go(PR_R_IP);
    `CHK(evRxAbort, 1'h1);
    // ========
    // Transmit faults: SYNC, link loss, escape
    for (k = 0; k < 3; k++)
    begin
      trTxRequest = 1'h1;
      go(PR_R_IP);
      trTxRequest = 1'h0;
      phyLinkUp = (k != 1);
      trEscape = (k == 2);
      go(k ? PR_R_IP : PR_SYNC);
      `CHK(evIllegal | evNoComm, k < 2);
      `CHK(linkState, k == 2 ? ST_FRAME_ESCAPE :
        (k == 1 ? ST_NO_COMM_ERROR : ST_IDLE));
      phyLinkUp = 1'h1;
      trEscape = 1'h0;
      go(PR_SYNC);
      go(PR_SYNC);
    end
    report_and_stop;
  end
endmodule : link_frame_tx_tail_rx_fsm_tb_top
